// ### hdl/chgreg_top.sv
/*
  Charger control register bank behind a two-wire serial slave, with host/standalone mode.
  Assumes open-drain SDA/SCL resolved outside; SCL is input only (no clock stretching).
*/
`timescale 1ns/1ps
module chgreg_top
  import chgreg_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR           = 7'h50,
  parameter logic        SELECT_PIN_VARIANT = 1'b0,
  parameter logic [31:0] WDOG_CYCLES        = CHGREG_WDOG_CYCLES
) (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  input  wire logic [1:0] i_source_detection_result,
  input  wire logic       i_limit_select_pin_high,
  input  wire logic       i_limit_select_pin_low,
  input  wire logic       i_watchdog_enable,
  input  wire logic       i_stat_request,
  input  wire logic       i_term_detected,
  output logic            o_stat_out,
  output logic            o_stat_oe,
  output logic            o_term_indicated,
  output logic            o_host_mode,
  output chgreg_settings_t o_settings
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic       scl_s1, scl_s2, scl_d;
  logic       sda_s1, sda_s2, sda_d;
  logic [1:0] pins_s1, pins_s2;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      scl_s1  <= 1'b1;
      scl_s2  <= 1'b1;
      scl_d   <= 1'b1;
      sda_s1  <= 1'b1;
      sda_s2  <= 1'b1;
      sda_d   <= 1'b1;
      pins_s1 <= 2'h0;
      pins_s2 <= 2'h0;
    end else begin
      scl_s1  <= i_scl;
      scl_s2  <= scl_s1;
      scl_d   <= scl_s2;
      sda_s1  <= i_sda;
      sda_s2  <= sda_s1;
      sda_d   <= sda_s2;
      pins_s1 <= {i_limit_select_pin_high, i_limit_select_pin_low};
      pins_s2 <= pins_s1;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s2 && !scl_d;
  assign scl_fall  = !scl_s2 && scl_d;
  assign bus_start = scl_s2 && scl_d && sda_d && !sda_s2;
  assign bus_stop  = scl_s2 && scl_d && !sda_d && sda_s2;

  // ------------------------------------------------------------
  // register storage and read decode
  // ------------------------------------------------------------
  logic [6:0] input_ctrl_r;
  logic [5:0] vreg_r;
  logic [7:0] chg_curr_r;
  logic [7:0] pointer_r;
  logic [1:0] source_field;
  logic [7:0] rd_data;

  assign source_field = SELECT_PIN_VARIANT ? pins_s2 : i_source_detection_result;  // [RL13] [RL14]

  always_comb begin
    rd_data = 8'h00;
    unique case (pointer_r)
      CHGREG_OFF_INPUT_CTRL: rd_data = {1'b0, input_ctrl_r};  // [RL20]
      CHGREG_OFF_BATT_VOLT:  rd_data = {vreg_r, source_field};
      CHGREG_OFF_CHG_CURR:   rd_data = chg_curr_r;
      default:               rd_data = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // serial slave engine
  // ------------------------------------------------------------
  chgreg_state_t state_r;
  logic [3:0]    bit_cnt_r;
  logic [7:0]    shift_r;
  logic [7:0]    tx_r;
  logic          read_dir_r;
  logic          ptr_phase_r;
  logic          master_ack_r;
  logic          byte_done;
  logic          addr_match;
  logic          wr_byte_end;
  logic          reg_write;
  logic          ptr_write;
  logic          rd_advance;

  assign byte_done   = scl_fall && (bit_cnt_r == 4'd8);
  assign addr_match  = (shift_r[7:1] == DEV_ADDR);
  assign wr_byte_end = (state_r == CHGREG_ST_WRBYTE) && byte_done;
  assign reg_write   = wr_byte_end && !ptr_phase_r;
  assign ptr_write   = wr_byte_end && ptr_phase_r;
  assign rd_advance  = (state_r == CHGREG_ST_RDBYTE) && byte_done;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
    end else if (bus_start || (scl_fall && bit_cnt_r == 4'd9) || byte_done) begin
      bit_cnt_r <= (bus_start || bit_cnt_r == 4'd9) ? 4'h0 : bit_cnt_r;
    end else if (scl_rise) begin
      bit_cnt_r <= bit_cnt_r + 4'd1;
      shift_r   <= {shift_r[6:0], sda_s2};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_r      <= CHGREG_ST_IDLE;
      o_sda_oe     <= 1'b0;
      read_dir_r   <= 1'b0;
      ptr_phase_r  <= 1'b0;
      master_ack_r <= 1'b0;
      tx_r         <= 8'h00;
    end else if (bus_stop) begin
      state_r  <= CHGREG_ST_IDLE;
      o_sda_oe <= 1'b0;
    end else if (bus_start) begin
      state_r     <= CHGREG_ST_ADDR;
      o_sda_oe    <= 1'b0;
      ptr_phase_r <= 1'b1;
    end else begin
      unique case (state_r)
        CHGREG_ST_IDLE: begin
          o_sda_oe <= 1'b0;
        end
        CHGREG_ST_ADDR: begin
          if (byte_done) begin
            state_r    <= addr_match ? CHGREG_ST_ADDRACK : CHGREG_ST_IDLE;
            o_sda_oe   <= addr_match;
            read_dir_r <= shift_r[0];
          end
        end
        CHGREG_ST_ADDRACK: begin
          if (scl_fall) begin
            state_r  <= read_dir_r ? CHGREG_ST_RDBYTE : CHGREG_ST_WRBYTE;
            tx_r     <= rd_data;
            o_sda_oe <= read_dir_r && !rd_data[7];
          end
        end
        CHGREG_ST_WRBYTE: begin
          if (byte_done) begin
            state_r     <= CHGREG_ST_WRACK;
            o_sda_oe    <= 1'b1;
            ptr_phase_r <= 1'b0;
          end
        end
        CHGREG_ST_WRACK: begin
          if (scl_fall) begin
            state_r  <= CHGREG_ST_WRBYTE;
            o_sda_oe <= 1'b0;
          end
        end
        CHGREG_ST_RDBYTE: begin
          if (byte_done) begin
            state_r  <= CHGREG_ST_RDACK;
            o_sda_oe <= 1'b0;
          end else if (scl_fall) begin
            tx_r     <= {tx_r[6:0], 1'b0};
            o_sda_oe <= !tx_r[6];
          end
        end
        CHGREG_ST_RDACK: begin
          if (scl_rise) begin
            master_ack_r <= !sda_s2;
          end
          if (scl_fall) begin
            state_r  <= master_ack_r ? CHGREG_ST_RDBYTE : CHGREG_ST_IDLE;
            tx_r     <= rd_data;
            o_sda_oe <= master_ack_r && !rd_data[7];
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // pointer
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pointer_r <= 8'h00;
    end else if (ptr_write) begin
      pointer_r <= shift_r;
    end else if (reg_write || rd_advance) begin
      pointer_r <= pointer_r + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // watchdog and host mode
  // ------------------------------------------------------------
  logic wdog_expired;

  chgreg_watchdog #(
    .WDOG_CYCLES (WDOG_CYCLES)
  ) u_watchdog (
    .i_mclk    (i_mclk),
    .i_reset   (i_reset),
    .i_enable  (i_watchdog_enable),
    .i_restart (reg_write),
    .o_expired (wdog_expired)
  );

  logic soft_reset;
  assign soft_reset = reg_write && (pointer_r == CHGREG_OFF_INPUT_CTRL) && shift_r[CHGREG_BIT_SOFT_RESET];

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_host_mode <= 1'b0;
    end else if (reg_write) begin
      o_host_mode <= 1'b1;  // [RL5]
    end else if (wdog_expired) begin
      o_host_mode <= 1'b0;  // [RL5] [RL19]
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset || soft_reset || (wdog_expired && !reg_write)) begin
      input_ctrl_r <= CHGREG_RST_INPUT_CTRL[6:0];  // [RL1] [RL19]
      vreg_r       <= CHGREG_RST_BATT_VOLT[7:2];   // [RL12]
      chg_curr_r   <= CHGREG_RST_CHG_CURR;
    end else if (reg_write) begin
      if (pointer_r == CHGREG_OFF_INPUT_CTRL) begin
        input_ctrl_r <= shift_r[6:0];
      end
      if (pointer_r == CHGREG_OFF_BATT_VOLT) begin
        vreg_r <= shift_r[7:2];
      end
      if (pointer_r == CHGREG_OFF_CHG_CURR) begin
        chg_curr_r <= shift_r;
      end
    end
  end

  // ------------------------------------------------------------
  // effective settings
  // ------------------------------------------------------------
  logic [2:0]       limit_code;
  logic [4:0]       ccur_code;
  logic [2:0]       tcur_code;
  logic             term_en;
  logic             limit_ext;
  logic             ccur_ext;
  chgreg_settings_t settings_nxt;

  assign limit_code = input_ctrl_r[CHGREG_POS_LIMIT +: 3];
  assign ccur_code  = chg_curr_r[CHGREG_POS_CCUR +: 5];
  assign tcur_code  = chg_curr_r[2:0];
  assign term_en    = input_ctrl_r[CHGREG_BIT_TERM_EN];
  assign limit_ext  = !o_host_mode || (limit_code == CHGREG_LIMIT_EXT);  // [RL3] [RL4]
  assign ccur_ext   = (ccur_code == CHGREG_CCUR_EXT);                    // [RL16]

  always_comb begin
    settings_nxt = '0;
    settings_nxt.input_limit_ma        = limit_ext ? 12'h000 : chgreg_limit_ma(limit_code);  // [RL2] [RL3]
    settings_nxt.input_limit_from_resistor = limit_ext;                                      // [RL4]
    settings_nxt.production_test_mode  = o_host_mode && (limit_code == CHGREG_LIMIT_TST);    // [RL3]
    settings_nxt.battery_regulation_mv =
      chgreg_scale(CHGREG_VREG_BASE_MV, CHGREG_VREG_STEP_MV, vreg_r);                        // [RL11]
    settings_nxt.charge_current_ma     = ccur_ext ? 12'h000 :
      12'(chgreg_scale(CHGREG_CCUR_BASE_MA, CHGREG_CCUR_STEP_MA, {1'b0, ccur_code}));        // [RL15]
    settings_nxt.charge_from_resistor  = ccur_ext;                                           // [RL16]
    settings_nxt.term_current_ma       = ccur_ext ? 12'h000 :
      12'(chgreg_scale(CHGREG_ITRM_BASE_MA, CHGREG_ITRM_STEP_MA, {3'b000, tcur_code}));      // [RL17]
    settings_nxt.term_ten_percent      = ccur_ext;                                           // [RL18]
    settings_nxt.term_enable           = term_en;                                            // [RL7]
    settings_nxt.battery_switch_on     =
      !input_ctrl_r[CHGREG_BIT_CHG_DISABLE] || input_ctrl_r[CHGREG_BIT_STANDBY];             // [RL9] [RL10]
    settings_nxt.converter_enable      = !input_ctrl_r[CHGREG_BIT_STANDBY];                  // [RL10]
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  logic term_shown;
  assign term_shown = i_term_detected && term_en;  // [RL8]

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_settings       <= '0;
      o_stat_oe        <= 1'b0;
      o_stat_out       <= 1'b0;
      o_term_indicated <= 1'b0;
      o_sda_out        <= 1'b0;
    end else begin
      o_settings       <= settings_nxt;
      o_stat_oe        <= input_ctrl_r[CHGREG_BIT_STAT_EN] && i_stat_request
                          && !(i_term_detected && !term_en);  // [RL6] [RL8]
      o_stat_out       <= 1'b0;
      o_term_indicated <= term_shown;  // [RL8]
      o_sda_out        <= 1'b0;
    end
  end

endmodule : chgreg_top

// ### hdl/chgreg_pkg.sv
/*
  Shared constants, field layout and settings carrier of the charger control register bank.
  Assumes a single 50 MHz clock and a host reaching the registers over the two-wire serial bus.
*/
// What this block does
// [RL1] writing one to input control bit7 resets registers
// [RL2] limit codes 000-101 select 100mA to 2000mA
// [RL3] code 110 external resistor, 111 unlimited 3A clamp
// [RL4] host mode uses field, standalone uses resistor
// [RL5] standalone until first write or watchdog expiry
// [RL6] status enable zero keeps status output released
// [RL7] termination enable bit switches charge termination
// [RL8] termination disabled hides all termination indication
// [RL9] charge disable turns battery switch off
// [RL10] standby disables converter, keeps battery switch on
// [RL11] regulation voltage is 3.5V plus 20mV steps
// [RL12] regulation field resets to 100011, 4.2V
// [RL13] read-only source detection result, two bits
// [RL14] select-pin variants report the two pin levels
// [RL15] charge current is 500mA plus 50mA steps
// [RL16] all-ones charge field selects external resistor
// [RL17] termination current is 50mA plus 25mA steps
// [RL18] external charge mode gives ten percent termination
// [RL19] 50 s watchdog restarts on writes, expiry reloads
// [RL20] register reset bit always reads back zero
package chgreg_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] CHGREG_OFF_INPUT_CTRL = 8'h01;
  localparam logic [7:0] CHGREG_OFF_BATT_VOLT  = 8'h02;
  localparam logic [7:0] CHGREG_OFF_CHG_CURR   = 8'h03;

  localparam logic [7:0] CHGREG_RST_INPUT_CTRL = 8'hac;
  localparam logic [7:0] CHGREG_RST_BATT_VOLT  = 8'h8f;
  localparam logic [7:0] CHGREG_RST_CHG_CURR   = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CHGREG_BIT_SOFT_RESET   = 7;
  localparam int CHGREG_POS_LIMIT        = 4;
  localparam int CHGREG_BIT_STAT_EN      = 3;
  localparam int CHGREG_BIT_TERM_EN      = 2;
  localparam int CHGREG_BIT_CHG_DISABLE  = 1;
  localparam int CHGREG_BIT_STANDBY      = 0;
  localparam int CHGREG_POS_VREG         = 2;
  localparam int CHGREG_POS_CCUR         = 3;

  // ------------------------------------------------------------
  // analog scaling
  // ------------------------------------------------------------
  localparam int CHGREG_VREG_BASE_MV = 3500;
  localparam int CHGREG_VREG_STEP_MV = 20;
  localparam int CHGREG_CCUR_BASE_MA = 500;
  localparam int CHGREG_CCUR_STEP_MA = 50;
  localparam int CHGREG_ITRM_BASE_MA = 50;
  localparam int CHGREG_ITRM_STEP_MA = 25;
  localparam int CHGREG_TST_CLAMP_MA = 3000;
  localparam logic [2:0] CHGREG_LIMIT_EXT = 3'b110;
  localparam logic [2:0] CHGREG_LIMIT_TST = 3'b111;
  localparam logic [4:0] CHGREG_CCUR_EXT  = 5'h1f;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint CHGREG_CLK_HZ       = 50_000_000;
  localparam longint CHGREG_WDOG_TIME_S  = 50;
  localparam logic [31:0] CHGREG_WDOG_CYCLES = 32'(CHGREG_WDOG_TIME_S * CHGREG_CLK_HZ);

  // ------------------------------------------------------------
  // bus engine states
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    CHGREG_ST_IDLE    = 7'b0000001,
    CHGREG_ST_ADDR    = 7'b0000010,
    CHGREG_ST_ADDRACK = 7'b0000100,
    CHGREG_ST_WRBYTE  = 7'b0001000,
    CHGREG_ST_WRACK   = 7'b0010000,
    CHGREG_ST_RDBYTE  = 7'b0100000,
    CHGREG_ST_RDACK   = 7'b1000000
  } chgreg_state_t;

  typedef struct packed {
    logic [11:0] input_limit_ma;
    logic        input_limit_from_resistor;
    logic        production_test_mode;
    logic [12:0] battery_regulation_mv;
    logic [11:0] charge_current_ma;
    logic        charge_from_resistor;
    logic [11:0] term_current_ma;
    logic        term_ten_percent;
    logic        term_enable;
    logic        battery_switch_on;
    logic        converter_enable;
  } chgreg_settings_t;

  // ------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------
  function automatic logic [11:0] chgreg_limit_ma(input logic [2:0] code);
    logic [11:0] ma;
    ma = 12'h000;
    unique case (code)
      3'b000: ma = 12'd100;
      3'b001: ma = 12'd150;
      3'b010: ma = 12'd500;
      3'b011: ma = 12'd900;
      3'b100: ma = 12'd1500;
      3'b101: ma = 12'd2000;
      3'b110: ma = 12'h000;
      3'b111: ma = 12'(CHGREG_TST_CLAMP_MA);
    endcase
    return ma;
  endfunction : chgreg_limit_ma

  function automatic logic [12:0] chgreg_scale(input int base, input int step, input logic [5:0] code);
    return 13'(base + step * int'(code));
  endfunction : chgreg_scale

endpackage : chgreg_pkg

// ### hdl/chgreg_watchdog.sv
/*
  Host watchdog: restarts on each host write, pulses once on expiry.
  Assumes restart is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
module chgreg_watchdog
  import chgreg_pkg::*;
#(
  parameter logic [31:0] WDOG_CYCLES = CHGREG_WDOG_CYCLES
) (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_enable,
  input  wire logic i_restart,
  output logic      o_expired
);

  logic [31:0] count_r;
  logic        running_r;
  logic        hit;

  assign hit = running_r && (count_r == WDOG_CYCLES - 32'd1);

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset || !i_enable) begin
      count_r   <= 32'h0;
      running_r <= 1'b0;
      o_expired <= 1'b0;
    end else if (i_restart) begin
      count_r   <= 32'h0;  // [RL19]
      running_r <= 1'b1;
      o_expired <= 1'b0;
    end else begin
      count_r   <= hit ? 32'h0 : count_r + {31'h0, running_r};
      running_r <= running_r && !hit;
      o_expired <= hit;  // [RL19]
    end
  end

endmodule : chgreg_watchdog

// ### verification/chgreg_top_monitor.sv
/*
  Port-level checker of the charger register bank, bound into chgreg_top.
  Assumes one clock domain and synchronous active-high reset.
*/
`timescale 1ns/1ps
module chgreg_top_monitor
  import chgreg_pkg::*;
(
  input wire logic             i_mclk,
  input wire logic             i_reset,
  input wire logic             i_scl,
  input wire logic             i_stat_request,
  input wire logic             i_term_detected,
  input wire logic             o_sda_out,
  input wire logic             o_sda_oe,
  input wire logic             o_stat_out,
  input wire logic             o_stat_oe,
  input wire logic             o_term_indicated,
  input wire logic             o_host_mode,
  input wire chgreg_settings_t o_settings
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  // ------------------------------------------------------------
  // settle counter after reset release
  // ------------------------------------------------------------
  logic [1:0] settle_r;
  logic       rdy;
  assign rdy = (settle_r == 2'h3);
  always_ff @(posedge i_mclk) begin
    if (i_reset)
      settle_r <= 2'h0;
    else if (!rdy)
      settle_r <= settle_r + 2'h1;
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_open_drain_low: assert property (o_sda_out == 1'b0 && o_stat_out == 1'b0)
    else $error("open-drain pin driven high");
  a_term_shown_gate: assert property (rdy |->
    o_term_indicated == ($past(i_term_detected) && o_settings.term_enable))
    else $error("termination indication wrong");
  a_stat_term_hide: assert property (rdy && o_stat_oe |-> $past(i_stat_request)
    && !($past(i_term_detected) && !o_settings.term_enable))
    else $error("status pin asserted without cause");
  a_standby_keeps_switch: assert property (rdy && !o_settings.converter_enable |->
    o_settings.battery_switch_on)
    else $error("standby turned battery switch off");
  a_ext_charge_mode: assert property (rdy && o_settings.charge_from_resistor |->
    o_settings.charge_current_ma == 12'h000 && o_settings.term_ten_percent)
    else $error("resistor charge mode wrong");
  a_charge_step_range: assert property (rdy && !o_settings.charge_from_resistor |->
    !o_settings.term_ten_percent
    && o_settings.charge_current_ma inside {[500:2000]} && o_settings.charge_current_ma % 50 == 0
    && o_settings.term_current_ma inside {[50:225]} && o_settings.term_current_ma % 25 == 0)
    else $error("charge or termination current off grid");
  a_vreg_step_range: assert property (rdy |-> o_settings.battery_regulation_mv inside {[3500:4760]}
    && o_settings.battery_regulation_mv % 20 == 0)
    else $error("regulation voltage off grid");
  a_test_limit_clamp: assert property (rdy && o_settings.production_test_mode |->
    o_settings.input_limit_ma == 12'd3000 && !o_settings.input_limit_from_resistor && $past(o_host_mode))
    else $error("test mode clamp wrong");
  a_standalone_resistor: assert property (rdy && !o_host_mode && !$past(o_host_mode)
    |-> o_settings.input_limit_from_resistor)
    else $error("standalone limit not from resistor");
  a_sda_after_fall: assert property (rdy && $changed(o_sda_oe) |-> !i_scl && !$past(i_scl))
    else $error("data line moved while clock high");
endmodule : chgreg_top_monitor

bind chgreg_top chgreg_top_monitor mon (.i_mclk(i_mclk), .i_reset(i_reset), .i_scl(i_scl),
  .i_stat_request(i_stat_request), .i_term_detected(i_term_detected), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_stat_out(o_stat_out), .o_stat_oe(o_stat_oe),
  .o_term_indicated(o_term_indicated), .o_host_mode(o_host_mode), .o_settings(o_settings));

// ### verification/chgreg_host_model.sv
/*
  Host side of the two-wire bus: byte write and pointer read tasks.
  Assumes SDA pull-up resolved by the bench; all changes at falling mclk edges.
*/
`timescale 1ns/1ps
module chgreg_host_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input  wire logic i_mclk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  logic nack_seen;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    nack_seen = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : tick

  // clock high 6 cycles, sampled mid-high
  task automatic clk_bit(output logic b);
    tick(6);
    o_scl = 1'b1;
    tick(3);
    b = i_sda;
    tick(3);
    o_scl = 1'b0;
  endtask : clk_bit

  // start condition: data pulled low while the clock is high
  task automatic start;
    o_sda_low = 1'b0;
    tick(6);
    o_scl = 1'b1;
    tick(6);
    o_sda_low = 1'b1;
    tick(6);
    o_scl = 1'b0;
  endtask : start

  task automatic stop;
    o_sda_low = 1'b1;
    tick(6);
    o_scl = 1'b1;
    tick(6);
    o_sda_low = 1'b0;
    tick(6);
  endtask : stop

  task automatic tx(input logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      tick(2);
      o_sda_low = ~d[i];
      clk_bit(b);
    end
    tick(2);
    o_sda_low = 1'b0;
    clk_bit(b);
    if (b)
      nack_seen = 1'b1;
  endtask : tx

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    start();
    tx({ADDR, 1'b0});
    tx(p);
    tx(d);
    stop();
  endtask : wr

  // last byte answered with nack to end the read
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic b;
    start();
    tx({ADDR, 1'b0});
    tx(p);
    start();
    tx({ADDR, 1'b1});
    tick(2);
    o_sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b);
      d[i] = b;
    end
    clk_bit(b);
    stop();
  endtask : rd
endmodule : chgreg_host_model

// ### verification/test_charger_control_registers.sv
/*
  Self-checking bench of the charger register bank with a host bus model.
  Assumes the short watchdog count below and the package constants.
*/
`timescale 1ns/1ps
module test_charger_control_registers;
  import chgreg_pkg::*;
  localparam logic [31:0] WDOG = 32'd1000;
  logic             mclk;
  logic             reset;
  logic             scl;
  logic             sda_line;
  logic             host_low;
  logic             sda_oe;
  logic [1:0]       src;
  logic             pin_hi;
  logic             pin_lo;
  logic             wd_en;
  logic             stat_req;
  logic             term_det;
  logic             stat_oe;
  logic             host_mode;
  chgreg_settings_t s;
  int               fail_count;
  int               checked;

  assign sda_line = ~(host_low | sda_oe);

  chgreg_top #(.WDOG_CYCLES(WDOG)) uut (.i_mclk(mclk), .i_reset(reset), .i_scl(scl), .i_sda(sda_line),
    .o_sda_out(), .o_sda_oe(sda_oe), .i_source_detection_result(src), .i_limit_select_pin_high(pin_hi),
    .i_limit_select_pin_low(pin_lo), .i_watchdog_enable(wd_en), .i_stat_request(stat_req),
    .i_term_detected(term_det), .o_stat_out(), .o_stat_oe(stat_oe), .o_term_indicated(),
    .o_host_mode(host_mode), .o_settings(s));
  chgreg_host_model host (.i_mclk(mclk), .i_sda(sda_line), .o_scl(scl), .o_sda_low(host_low));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  function automatic logic [31:0] exp_limit(input logic [2:0] c);
    logic [31:0] t[8] = '{100, 150, 500, 900, 1500, 2000, 0, 3000};
    return t[c];
  endfunction : exp_limit

  function automatic logic [31:0] lin(input int base, input int stp, input int v, input logic ext);
    return ext ? 0 : base + stp * v;
  endfunction : lin

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // random status, termination and limit select pin stimulus
  always @(negedge mclk) begin
    stat_req = 1'($urandom);
    term_det = 1'($urandom);
    pin_hi = 1'($urandom);
    pin_lo = 1'($urandom);
  end

  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    end_sim();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] v;
    logic [5:0] vb;
    logic [4:0] cc;
    logic [2:0] t;
    void'($urandom(60));
    {reset, wd_en, src, fail_count, checked} = {1'b1, 1'b0, 2'h2, 64'h0};
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    host.rd(8'h01, d);
    check("ctl default", d, 8'h2c);
    host.rd(8'h02, d);
    check("vbat default", d, 8'h8e);
    host.rd(8'h03, d);
    check("chg default", d, 8'h00);
    check("vreg default", s.battery_regulation_mv, 4200);
    check("standalone", {host_mode, s.input_limit_from_resistor}, 2'b01);
    $display("test defaults done");
    for (int c = 0; c < 8; c++) begin
      v = {1'b0, c[2:0], 4'($urandom)};
      host.wr(8'h01, v);
      host.rd(8'h01, d);
      check("ctl rb", d, v);
      check("host mode", host_mode, 1'b1);
      check("limit ma", s.input_limit_ma, exp_limit(c[2:0]));
      check("limit res", s.input_limit_from_resistor, c == 6);
      check("test mode", s.production_test_mode, c == 7);
      check("term en", s.term_enable, v[2]);
      check("bat switch", s.battery_switch_on, !v[1] | v[0]);
      check("converter", s.converter_enable, !v[0]);
      check("stat off", stat_oe && !v[3], 1'b0);
    end
    $display("test limits done");
    for (int i = 0; i < 6; i++) begin
      vb = (i == 0) ? 6'h3f : 6'($urandom);
      cc = (i == 1) ? 5'h1f : (i == 2) ? 5'h1e : 5'($urandom);
      t = 3'($urandom);
      src = 2'(i);
      host.wr(8'h02, {vb, 2'h3});
      host.wr(8'h03, {cc, t});
      host.rd(8'h02, d);
      check("vbat rb", d, {vb, src});
      host.rd(8'h03, d);
      check("chg rb", d, {cc, t});
      check("vreg mv", s.battery_regulation_mv, lin(3500, 20, vb, 0));
      check("chg ma", s.charge_current_ma, lin(500, 50, cc, cc == 31));
      check("chg res", {s.charge_from_resistor, s.term_ten_percent}, {2{cc == 31}});
      check("term ma", s.term_current_ma, lin(50, 25, t, cc == 31));
    end
    $display("test currents done");
    host.wr(8'h01, 8'h80 | 8'($urandom));
    host.rd(8'h01, d);
    check("soft ctl", d, 8'h2c);
    host.rd(8'h02, d);
    check("soft vbat", d, {6'h23, src});
    host.rd(8'h03, d);
    check("soft chg", d, 8'h00);
    host.rd(8'h05, d);
    check("unmapped", d, 8'h00);
    $display("test soft reset done");
    wd_en = 1'b1;
    host.wr(8'h03, 8'h55);
    repeat (900) @(negedge mclk);
    check("wdog alive", host_mode, 1'b1);
    repeat (200) @(negedge mclk);
    check("wdog expired", {host_mode, s.input_limit_from_resistor}, 2'b01);
    host.rd(8'h03, d);
    check("wdog reload", d, 8'h00);
    check("bus acks", host.nack_seen, 1'b0);
    $display("test watchdog done");
    end_sim();
  end
endmodule : test_charger_control_registers
